// ==== rtl/can_event_fifo.sv ====
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
// How it works
// - received frames get type 1, 2, 9 or 12 by id type and remote bit
// - confirmed transmissions get type 3, 8, 10 or 11
// - bus state change logs type 5, error frame type 15, no other codes
// - received data frames report payload length zero to eight
// - each record takes a microsecond timestamp at the event
// - each record carries an eight byte payload
// - popping an empty receive queue returns a record of type zero
// - receive queue holds 255 records
// - events arriving at a full receive queue are dropped and counted
// - bus state readable: 0 active, 1 passive, 2 bus off
// - transmit queue holds 255 messages, writes when full are dropped
// - transmit level readable at any time
// - receive level readable at any time
// - transmit reset bit one empties transmit queue, zero does nothing
// - receive reset empties receive queue and zeroes its level
// - filter includes or excludes a set of event types
// - filter includes or excludes a list of identifiers
// - last matching record overwrites earlier ones in filter output
// - filter counts matching records it has processed
// - record holds port, id, type, length, timestamp, payload in order
// - port field 1 or 2, ids 11 or 29 bits
// - error frames queued only while error detection is enabled
// - transmit entry holds port, id, id type, length, payload; sent to bus
module can_event_fifo
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic EVT_VALID,
  input wire can_event_pkg::evt_kind_type EVT_KIND,
  input wire logic [can_event_pkg::PORT_W-1:0] EVT_PORT,
  input wire logic [can_event_pkg::ID_W-1:0] EVT_ID,
  input wire logic EVT_EXT,
  input wire logic EVT_RTR,
  input wire logic [can_event_pkg::LEN_W-1:0] EVT_LEN,
  input wire logic [can_event_pkg::PAYLOAD_W-1:0] EVT_DATA,
  input wire logic [1:0] BUS_STATE_1,
  input wire logic [1:0] BUS_STATE_2,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [can_event_pkg::PORT_W-1:0] TX_PORT,
  output logic [can_event_pkg::ID_W-1:0] TX_ID,
  output logic TX_EXT,
  output logic [can_event_pkg::LEN_W-1:0] TX_LEN,
  output logic [can_event_pkg::PAYLOAD_W-1:0] TX_DATA
);
  import can_event_pkg::*;

  // ----------------------------------------------------------------
  // wishbone slave decode
  // ----------------------------------------------------------------
  logic access_go;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_word;
  logic [31:0] reg_view [0:REG_WORDS-1];
  logic [4:0] word_idx;

  // request taken on the first cycle, acked one cycle later
  assign access_go = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_go = access_go & WB_WE_I;
  assign rd_go = access_go & ~WB_WE_I;
  assign word_idx = WB_ADR_I[6:2];
  assign rd_word = (WB_ADR_I[7] == 1'b0 && int'(word_idx) < REG_WORDS) ? reg_view[word_idx] : 32'h0000_0000;

  // byte lane merge for read-write registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[8*b +: 8] = din[8*b +: 8];
    return res;
  endfunction : merge

  // ack and read data
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= access_go;
      WB_DAT_O <= rd_go ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] fctl;
  logic [31:0] ftypes;
  logic [31:0] fid [0:FILT_IDS-1];
  logic [ID_W-1:0] stage_id;
  logic [PAYLOAD_W-1:0] stage_data;
  logic errf_en;

  assign errf_en = ctrl[CTRL_ERRF_BIT];

  // plain stores, written through byte lanes
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ctrl <= CTRL_RESET;
      fctl <= FCTL_RESET;
      ftypes <= FTYPES_RESET;
      stage_id <= '0;
      stage_data <= '0;
    end
    else if (wr_go)
    begin
      if (WB_ADR_I == A_CTRL)
        ctrl <= merge(ctrl, WB_DAT_I, WB_SEL_I);
      if (WB_ADR_I == A_FCTL)
        fctl <= merge(fctl, WB_DAT_I, WB_SEL_I) & ~(32'h0000_0001 << FCTL_CLR_BIT);
      if (WB_ADR_I == A_FTYPES)
        ftypes <= merge(ftypes, WB_DAT_I, WB_SEL_I);
      if (WB_ADR_I == A_TX_ID)
        stage_id <= ID_W'(merge(32'(stage_id), WB_DAT_I, WB_SEL_I));
      if (WB_ADR_I == A_TX_DLO)
        stage_data[31:0] <= merge(stage_data[31:0], WB_DAT_I, WB_SEL_I);
      if (WB_ADR_I == A_TX_DHI)
        stage_data[63:32] <= merge(stage_data[63:32], WB_DAT_I, WB_SEL_I);
    end
  end

  // identifier list, one word per entry
  genvar gi;
  generate
    for (gi = 0; gi < FILT_IDS; gi++)
    begin : g_fid
      always_ff @(posedge CLOCK)
      begin
        if (RST)
          fid[gi] <= FID_RESET;
        else if (wr_go && WB_ADR_I == A_FID0 + 8'(4 * gi))
          fid[gi] <= merge(fid[gi], WB_DAT_I, WB_SEL_I);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // queue reset commands
  // ----------------------------------------------------------------
  logic qreset_go;
  logic tx_clear;
  logic rx_clear;

  assign qreset_go = wr_go & (WB_ADR_I == A_QRESET) & WB_SEL_I[0];
  assign tx_clear = qreset_go & WB_DAT_I[QRST_TX_BIT];
  assign rx_clear = qreset_go & WB_DAT_I[QRST_RX_BIT];

  // ----------------------------------------------------------------
  // microsecond timestamp
  // ----------------------------------------------------------------
  logic [7:0] tick_count;
  logic [TS_W-1:0] timestamp;

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      tick_count <= 8'h00;
      timestamp <= '0;
    end
    else if (tick_count == 8'(TICK_CYCLES - 1))
    begin
      tick_count <= 8'h00;
      timestamp <= timestamp + 1'b1;
    end
    else
      tick_count <= tick_count + 1'b1;
  end

  // ----------------------------------------------------------------
  // event record builder
  // ----------------------------------------------------------------
  logic [3:0] rx_code;
  logic [3:0] conf_code;
  logic [3:0] frame_code;
  logic [LEN_W-1:0] frame_len;
  logic frame_take;
  logic change1;
  logic change2;
  logic bus_take;
  logic [1:0] logged1;
  logic [1:0] logged2;
  logic [1:0] bus_new;
  logic [REC_W-1:0] frame_rec;
  logic [REC_W-1:0] bus_rec;
  logic [REC_W-1:0] evt_rec;
  logic evt_push;

  assign rx_code = EVT_EXT ? (EVT_RTR ? T_RX_EXT_REMOTE : T_RX_EXT_DATA)
                           : (EVT_RTR ? T_RX_STD_REMOTE : T_RX_STD_DATA);
  assign conf_code = EVT_EXT ? (EVT_RTR ? T_TX_EXT_REMOTE : T_TX_EXT_DATA)
                             : (EVT_RTR ? T_TX_STD_REMOTE : T_TX_STD_DATA);
  assign frame_code = (EVT_KIND == EVT_RX) ? rx_code
                    : (EVT_KIND == EVT_TXCONF) ? conf_code : T_ERROR_FRAME;
  assign frame_take = EVT_VALID & ((EVT_KIND == EVT_RX) | (EVT_KIND == EVT_TXCONF)
                    | ((EVT_KIND == EVT_ERROR) & errf_en));
  assign frame_len = (EVT_KIND != EVT_ERROR && !EVT_RTR) ? EVT_LEN : '0;
  assign frame_rec = {EVT_PORT, EVT_ID, frame_code, frame_len, timestamp, EVT_DATA};

  // bus state change, deferred a cycle behind a frame event
  assign change1 = (BUS_STATE_1 != logged1);
  assign change2 = (BUS_STATE_2 != logged2);
  assign bus_take = ~frame_take & (change1 | change2);
  assign bus_new = change1 ? BUS_STATE_1 : BUS_STATE_2;
  assign bus_rec = {(change1 ? PORT_ONE : PORT_TWO), {ID_W{1'b0}}, T_BUS_STATE, {LEN_W{1'b0}},
                    timestamp, {(PAYLOAD_W-2){1'b0}}, bus_new};
  assign evt_rec = frame_take ? frame_rec : bus_rec;
  assign evt_push = frame_take | bus_take;

  // last logged bus state per port
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      logged1 <= BUS_ERROR_ACTIVE;
      logged2 <= BUS_ERROR_ACTIVE;
    end
    else if (bus_take)
    begin
      if (change1)
        logged1 <= BUS_STATE_1;
      else
        logged2 <= BUS_STATE_2;
    end
  end

  // ----------------------------------------------------------------
  // receive queue and lost counter
  // ----------------------------------------------------------------
  logic [REC_W-1:0] rx_head;
  logic [LEVEL_W-1:0] rx_level;
  logic rx_full;
  logic rx_empty;
  logic pop_go;
  logic [REC_W-1:0] popped;
  logic [REC_W-1:0] rec;
  logic [LOST_W-1:0] lost;

  assign pop_go = rd_go & (WB_ADR_I == A_REC_POP);
  assign popped = rx_empty ? '0 : rx_head;

  can_ring_queue #(.WIDTH(REC_W), .DEPTH(QUEUE_DEPTH), .CW(LEVEL_W)) u_rx_queue
  (
    .clock(CLOCK),
    .rst(RST),
    .clear(rx_clear),
    .push(evt_push),
    .push_data(evt_rec),
    .pop(pop_go),
    .head(rx_head),
    .level(rx_level),
    .full(rx_full),
    .empty(rx_empty)
  );

  // dropped events counted, held at the top
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      lost <= '0;
    else if (evt_push & rx_full & ~rx_clear & ~(&lost))
      lost <= lost + 1'b1;
    else if (rx_clear)
      lost <= '0;
  end

  // record latched for the following reads
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      rec <= '0;
    else if (pop_go)
      rec <= popped;
  end

  // ----------------------------------------------------------------
  // event filter over popped records
  // ----------------------------------------------------------------
  logic port_ok;
  logic type_ok;
  logic id_ok;
  logic [FILT_IDS-1:0] id_hit;
  logic filt_match;
  logic filt_clear;
  logic [REC_W-1:0] frec;
  logic [31:0] fcount;
  logic [1:0] pop_port;
  logic [3:0] pop_type;

  assign pop_port = popped[REC_PORT_LSB +: PORT_W];
  assign pop_type = popped[REC_TYPE_LSB +: TYPE_W];
  assign port_ok = (fctl[FCTL_PORT_LSB +: 2] == PORT_ANY) | (fctl[FCTL_PORT_LSB +: 2] == pop_port);
  assign type_ok = ftypes[pop_type] ^ fctl[FCTL_TEXCL_BIT];
  assign id_ok = (|id_hit) ^ fctl[FCTL_IEXCL_BIT];
  assign filt_match = pop_go & port_ok & type_ok & id_ok;
  assign filt_clear = wr_go & (WB_ADR_I == A_FCTL) & WB_SEL_I[1] & WB_DAT_I[FCTL_CLR_BIT];

  // identifier compare per list entry
  generate
    for (gi = 0; gi < FILT_IDS; gi++)
    begin : g_idcmp
      assign id_hit[gi] = fid[gi][FID_USED_BIT] & (fid[gi][ID_W-1:0] == popped[REC_ID_LSB +: ID_W]);
    end
  endgenerate

  // latest match and match count
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      frec <= '0;
      fcount <= 32'h0000_0000;
    end
    else
    begin
      if (filt_match)
        frec <= popped;
      if (filt_clear)
        fcount <= {31'h0000_0000, filt_match};
      else if (filt_match)
        fcount <= fcount + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmit queue and output stage
  // ----------------------------------------------------------------
  logic [TXE_W-1:0] tx_head;
  logic [LEVEL_W-1:0] tx_level;
  logic tx_empty;
  logic [LEVEL_W:0] tx_total;
  logic tx_cmd_go;
  logic tx_push;
  logic tx_load;
  logic tx_pop;
  logic [TXE_W-1:0] tx_entry;

  assign tx_total = {1'b0, tx_level} + {{LEVEL_W{1'b0}}, TX_VALID};
  assign tx_cmd_go = wr_go & (WB_ADR_I == A_TX_CMD);
  assign tx_push = tx_cmd_go & (tx_total < (LEVEL_W+1)'(QUEUE_DEPTH));
  assign tx_entry = {WB_DAT_I[META_PORT_LSB +: PORT_W], stage_id, WB_DAT_I[CMD_EXT_BIT],
                     WB_DAT_I[META_LEN_LSB +: LEN_W], stage_data};
  assign tx_load = ~TX_VALID | TX_READY;
  assign tx_pop = tx_load & ~tx_empty & ~tx_clear;

  can_ring_queue #(.WIDTH(TXE_W), .DEPTH(QUEUE_DEPTH), .CW(LEVEL_W)) u_tx_queue
  (
    .clock(CLOCK),
    .rst(RST),
    .clear(tx_clear),
    .push(tx_push),
    .push_data(tx_entry),
    .pop(tx_pop),
    .head(tx_head),
    .level(tx_level),
    .full(),
    .empty(tx_empty)
  );

  // message offered to the protocol engine
  always_ff @(posedge CLOCK)
  begin
    if (RST | tx_clear)
    begin
      TX_VALID <= 1'b0;
      TX_PORT <= '0;
      TX_ID <= '0;
      TX_EXT <= 1'b0;
      TX_LEN <= '0;
      TX_DATA <= '0;
    end
    else if (tx_load)
    begin
      TX_VALID <= ~tx_empty;
      TX_PORT <= tx_head[TXE_PORT_LSB +: PORT_W];
      TX_ID <= tx_head[TXE_ID_LSB +: ID_W];
      TX_EXT <= tx_head[TXE_EXT_BIT];
      TX_LEN <= tx_head[TXE_LEN_LSB +: LEN_W];
      TX_DATA <= tx_head[TXE_DATA_LSB +: PAYLOAD_W];
    end
  end

  // ----------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------
  assign reg_view[0] = ctrl;
  assign reg_view[1] = {12'h000, BUS_STATE_2, BUS_STATE_1, tx_total[LEVEL_W-1:0], rx_level};
  assign reg_view[2] = {16'h0000, lost};
  assign reg_view[3] = 32'h0000_0000;
  assign reg_view[4] = {14'h0000, popped[REC_PORT_LSB +: PORT_W], 4'h0, popped[REC_LEN_LSB +: LEN_W],
                        4'h0, popped[REC_TYPE_LSB +: TYPE_W]};
  assign reg_view[5] = {3'h0, rec[REC_ID_LSB +: ID_W]};
  assign reg_view[6] = rec[REC_TS_LSB +: TS_W];
  assign reg_view[7] = rec[31:0];
  assign reg_view[8] = rec[63:32];
  assign reg_view[9] = {3'h0, stage_id};
  assign reg_view[10] = stage_data[31:0];
  assign reg_view[11] = stage_data[63:32];
  assign reg_view[12] = {14'h0000, tx_total[LEVEL_W-1:0] == 8'(QUEUE_DEPTH), 17'h00000};
  assign reg_view[13] = fctl;
  assign reg_view[14] = ftypes;
  assign reg_view[15] = fcount;

  generate
    for (gi = 0; gi < FILT_IDS; gi++)
    begin : g_fidview
      assign reg_view[16 + gi] = fid[gi];
    end
  endgenerate

  assign reg_view[20] = {14'h0000, frec[REC_PORT_LSB +: PORT_W], 4'h0, frec[REC_LEN_LSB +: LEN_W],
                         4'h0, frec[REC_TYPE_LSB +: TYPE_W]};
  assign reg_view[21] = {3'h0, frec[REC_ID_LSB +: ID_W]};
  assign reg_view[22] = frec[REC_TS_LSB +: TS_W];
  assign reg_view[23] = frec[31:0];
  assign reg_view[24] = frec[63:32];

endmodule : can_event_fifo

// ==== rtl/can_event_pkg.sv ====
package can_event_pkg;

  // ----------------------------------------------------------------
  // clock and timestamp tick
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS / CLK_PERIOD_NS < 1) ? 1 : TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int QUEUE_DEPTH = 255;
  localparam int LEVEL_W = 8;
  localparam int PORT_W = 2;
  localparam int ID_W = 29;
  localparam int TYPE_W = 4;
  localparam int LEN_W = 4;
  localparam int TS_W = 32;
  localparam int PAYLOAD_W = 64;
  localparam int LOST_W = 16;
  localparam int FILT_IDS = 4;

  // ----------------------------------------------------------------
  // event record layout: port, id, type, length, timestamp, payload
  // ----------------------------------------------------------------
  localparam int REC_DATA_LSB = 0;
  localparam int REC_TS_LSB = REC_DATA_LSB + PAYLOAD_W;
  localparam int REC_LEN_LSB = REC_TS_LSB + TS_W;
  localparam int REC_TYPE_LSB = REC_LEN_LSB + LEN_W;
  localparam int REC_ID_LSB = REC_TYPE_LSB + TYPE_W;
  localparam int REC_PORT_LSB = REC_ID_LSB + ID_W;
  localparam int REC_W = REC_PORT_LSB + PORT_W;

  // transmit entry layout: port, id, id type, length, payload
  localparam int TXE_DATA_LSB = 0;
  localparam int TXE_LEN_LSB = TXE_DATA_LSB + PAYLOAD_W;
  localparam int TXE_EXT_BIT = TXE_LEN_LSB + LEN_W;
  localparam int TXE_ID_LSB = TXE_EXT_BIT + 1;
  localparam int TXE_PORT_LSB = TXE_ID_LSB + ID_W;
  localparam int TXE_W = TXE_PORT_LSB + PORT_W;

  // ----------------------------------------------------------------
  // event type codes
  // ----------------------------------------------------------------
  localparam logic [3:0] T_NONE = 4'h0;
  localparam logic [3:0] T_RX_STD_DATA = 4'h1;
  localparam logic [3:0] T_RX_STD_REMOTE = 4'h2;
  localparam logic [3:0] T_TX_STD_DATA = 4'h3;
  localparam logic [3:0] T_BUS_STATE = 4'h5;
  localparam logic [3:0] T_TX_STD_REMOTE = 4'h8;
  localparam logic [3:0] T_RX_EXT_DATA = 4'h9;
  localparam logic [3:0] T_TX_EXT_DATA = 4'ha;
  localparam logic [3:0] T_TX_EXT_REMOTE = 4'hb;
  localparam logic [3:0] T_RX_EXT_REMOTE = 4'hc;
  localparam logic [3:0] T_ERROR_FRAME = 4'hf;

  // bus states and port choices
  localparam logic [1:0] BUS_ERROR_ACTIVE = 2'h0;
  localparam logic [1:0] BUS_ERROR_PASSIVE = 2'h1;
  localparam logic [1:0] BUS_OFF = 2'h2;
  localparam logic [1:0] PORT_ANY = 2'h0;
  localparam logic [1:0] PORT_ONE = 2'h1;
  localparam logic [1:0] PORT_TWO = 2'h2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_LOST = 8'h08;
  localparam logic [7:0] A_QRESET = 8'h0c;
  localparam logic [7:0] A_REC_POP = 8'h10;
  localparam logic [7:0] A_REC_ID = 8'h14;
  localparam logic [7:0] A_REC_TS = 8'h18;
  localparam logic [7:0] A_REC_DLO = 8'h1c;
  localparam logic [7:0] A_REC_DHI = 8'h20;
  localparam logic [7:0] A_TX_ID = 8'h24;
  localparam logic [7:0] A_TX_DLO = 8'h28;
  localparam logic [7:0] A_TX_DHI = 8'h2c;
  localparam logic [7:0] A_TX_CMD = 8'h30;
  localparam logic [7:0] A_FCTL = 8'h34;
  localparam logic [7:0] A_FTYPES = 8'h38;
  localparam logic [7:0] A_FCOUNT = 8'h3c;
  localparam logic [7:0] A_FID0 = 8'h40;
  localparam logic [7:0] A_FMETA = 8'h50;
  localparam logic [7:0] A_FID = 8'h54;
  localparam logic [7:0] A_FTS = 8'h58;
  localparam logic [7:0] A_FDLO = 8'h5c;
  localparam logic [7:0] A_FDHI = 8'h60;
  localparam int REG_WORDS = 25;

  // field positions
  localparam int CTRL_ERRF_BIT = 0;
  localparam int QRST_TX_BIT = 0;
  localparam int QRST_RX_BIT = 1;
  localparam int META_TYPE_LSB = 0;
  localparam int META_LEN_LSB = 8;
  localparam int META_PORT_LSB = 16;
  localparam int CMD_EXT_BIT = 12;
  localparam int ST_RXLVL_LSB = 0;
  localparam int ST_TXLVL_LSB = 8;
  localparam int ST_BUS1_LSB = 16;
  localparam int ST_BUS2_LSB = 18;
  localparam int FCTL_PORT_LSB = 0;
  localparam int FCTL_TEXCL_BIT = 4;
  localparam int FCTL_IEXCL_BIT = 5;
  localparam int FCTL_CLR_BIT = 8;
  localparam int FID_USED_BIT = 31;

  // reset values: filter passes everything
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FCTL_RESET = 32'h0000_0030;
  localparam logic [31:0] FTYPES_RESET = 32'h0000_0000;
  localparam logic [31:0] FID_RESET = 32'h0000_0000;

  // event source kinds on the engine side
  typedef enum logic [1:0] {
    EVT_RX = 2'b00,
    EVT_TXCONF = 2'b01,
    EVT_ERROR = 2'b10
  } evt_kind_type;

endpackage : can_event_pkg

// ==== rtl/can_ring_queue.sv ====
`timescale 1ns/1ps
module can_ring_queue
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 255,
  parameter int CW = 8
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic [CW-1:0] level,
  output logic full,
  output logic empty
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [CW-1:0] wptr;
  logic [CW-1:0] rptr;
  logic do_push;
  logic do_pop;

  // ----------------------------------------------------------------
  // flags and guarded strobes
  // ----------------------------------------------------------------
  assign full = (level == CW'(DEPTH));
  assign empty = (level == '0);
  assign do_push = push & ~full & ~clear;
  assign do_pop = pop & ~empty & ~clear;
  assign head = mem[rptr];

  // storage, no reset needed
  always_ff @(posedge clock)
  begin
    if (do_push)
      mem[wptr] <= push_data;
  end

  // pointers wrap at depth, clear wins
  always_ff @(posedge clock)
  begin
    if (rst | clear)
    begin
      wptr <= '0;
      rptr <= '0;
      level <= '0;
    end
    else
    begin
      if (do_push)
        wptr <= (wptr == CW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      if (do_pop)
        rptr <= (rptr == CW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      if (do_push & ~do_pop)
        level <= level + 1'b1;
      else if (do_pop & ~do_push)
        level <= level - 1'b1;
    end
  end

endmodule : can_ring_queue

// ==== verification/can_event_fifo_assertions.sv ====
`timescale 1ns/1ps
module can_event_fifo_checker
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic [1:0] TX_PORT,
  input wire logic [28:0] TX_ID,
  input wire logic [3:0] TX_LEN
);
  import can_event_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ----
  // bus and output checks
  // ----
  // tx reset may withdraw an offer
  wire tx_rst = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == A_QRESET && WB_DAT_I[0];
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_pop;
    s_req ##0 (WB_ADR_I == A_REC_POP && !WB_WE_I);
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> WB_ACK_O) else $error("ack late");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack unasked");
  AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data outside ack");
  AST_POP_TYPE: assert property (s_pop |=> !(WB_DAT_O[3:0] inside {4'h4, 4'h6, 4'h7, 4'hd, 4'he}))
    else $error("unused type code");
  AST_POP_LEN: assert property (s_pop |=> WB_DAT_O[11:8] <= 4'h8) else $error("length over eight");
  AST_POP_PORT: assert property (s_pop |=> WB_DAT_O[3:0] == 4'h0 || WB_DAT_O[17:16] inside {2'h1, 2'h2})
    else $error("bad port");
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY && !tx_rst |=> TX_VALID && $stable(TX_ID))
    else $error("offer changed");
  AST_TX_FIELDS: assert property (TX_VALID |-> TX_LEN <= 4'h8 && TX_PORT inside {2'h1, 2'h2})
    else $error("bad offer");
endmodule : can_event_fifo_checker
bind can_event_fifo can_event_fifo_checker chk (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_PORT(TX_PORT), .TX_ID(TX_ID),
  .TX_LEN(TX_LEN));

// ==== verification/can_engine_model.sv ====
`timescale 1ns/1ps
module can_engine_model
(
  input wire logic clock,
  input wire logic stall,
  input wire logic tx_valid,
  output logic tx_ready,
  output int sent
);
  // engine takes one message per handshake, or stalls
  assign tx_ready = !stall;
  initial sent = 0;
  always @(posedge clock)
    if (tx_valid && tx_ready) sent <= sent + 1;
endmodule : can_engine_model

// ==== verification/tb_can_event_fifo.sv ====
`timescale 1ns/1ps
module tb_can_event_fifo;
  import can_event_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ev = 0, ext = 0, rtr = 0, stall = 0, ack, txv, rdy;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rd, q;
  logic [1:0] port = 1, bs1 = 0, bs2 = 0, txp;
  logic [28:0] id = 0, txid;
  logic [3:0] len = 0, txl;
  logic [63:0] data = 0;
  evt_kind_type kind = EVT_RX;
  int n_fail = 0, total_checks = 0, sent;
  always #12.5 clk = ~clk;
  can_event_fifo dut (.CLOCK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .EVT_VALID(ev), .EVT_KIND(kind),
    .EVT_PORT(port), .EVT_ID(id), .EVT_EXT(ext), .EVT_RTR(rtr), .EVT_LEN(len), .EVT_DATA(data),
    .BUS_STATE_1(bs1), .BUS_STATE_2(bs2), .TX_VALID(txv), .TX_READY(rdy), .TX_PORT(txp), .TX_ID(txid),
    .TX_EXT(), .TX_LEN(txl), .TX_DATA());
  can_engine_model eng (.clock(clk), .stall(stall), .tx_valid(txv), .tx_ready(rdy), .sent(sent));
  // ----
  // shared tasks
  // ----
  task end_of_test;
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1 && ++i < 8);
    q = rd;
    {cyc, stb} <= 2'b00;
    if (i >= 8) chk(0, 1);
    if (i >= 8) end_of_test();
  endtask : wb
  task rc(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(q, e);
  endtask : rc
  task evt(input evt_kind_type k, input logic [1:0] p, input logic [28:0] i, input logic x, r, input logic [3:0] l);
    @(posedge clk);
    {ev, port, id, ext, rtr, len, data} <= {1'b1, p, i, x, r, l, 35'h0, i};
    kind <= k;
    @(posedge clk);
    ev <= 0;
  endtask : evt
  // ----
  // scenarios
  // ----
  task automatic t_types;
    logic [3:0] code [8] = '{4'h1, 4'h2, 4'h9, 4'hc, 4'h3, 4'h8, 4'ha, 4'hb};
    logic [31:0] ts = 0;
    for (int n = 0; n < 8; n++)
    begin
      if (n == 7) repeat (78) @(posedge clk);
      evt(evt_kind_type'(n / 4), n[0] ? 2'h2 : 2'h1, n, n[1], n[0], 4'h5);
    end
    rc(A_STATUS, 8);
    for (int n = 0; n < 8; n++)
    begin
      rc(A_REC_POP, {14'h0, n[0] ? 2'h2 : 2'h1, 4'h0, n[0] ? 4'h0 : 4'h5, 4'h0, code[n]});
      rc(A_REC_ID, n);
      rc(A_REC_DLO, n);
      wb(0, A_REC_TS, 0);
      if (n == 7) chk(q - ts, 2);
      ts = q;
    end
  endtask : t_types
  task t_reset;
    stall <= 1;
    for (int n = 0; n < 3; n++) evt(EVT_RX, 2'h1, 29'h7ff, 0, 0, 4'h8);
    wb(1, A_TX_ID, 32'h123);
    for (int n = 0; n < 2; n++) wb(1, A_TX_CMD, 32'h0001_0308);
    rc(A_STATUS, 32'h0203);
    chk({txv, txp, txl, 13'h0, txid[11:0]}, {1'b1, 2'h1, 4'h3, 25'h123});
    wb(1, A_QRESET, 0);
    rc(A_STATUS, 32'h0203);
    wb(1, A_QRESET, 2);
    rc(A_STATUS, 32'h0200);
    wb(1, A_QRESET, 1);
    stall <= 0;
    rc(A_STATUS, 0);
    rc(A_REC_POP, 0);
    rc(A_REC_ID, 0);
    chk(sent, 0);
  endtask : t_reset
  task t_err;
    evt(EVT_ERROR, 2'h1, 0, 0, 0, 4'h0);
    rc(A_STATUS, 0);
    wb(1, A_CTRL, 1);
    evt(EVT_ERROR, 2'h1, 0, 0, 0, 4'h0);
    bs1 <= BUS_OFF;
    bs2 <= BUS_ERROR_PASSIVE;
    repeat (2) @(posedge clk);
    rc(A_STATUS, 32'h0006_0003);
    rc(A_REC_POP, 32'h0001_000f);
    rc(A_REC_POP, 32'h0001_0005);
    rc(A_REC_DLO, 2);
    rc(A_REC_POP, 32'h0002_0005);
    rc(A_REC_DLO, 1);
  endtask : t_err
  task automatic t_full;
    int i = 0;
    for (int n = 0; n < 257; n++) evt(EVT_TXCONF, 2'h2, n, 1, 0, 4'h1);
    rc(A_STATUS, 32'h0006_00ff);
    rc(A_LOST, 2);
    wb(1, A_QRESET, 2);
    rc(A_LOST, 0);
    stall <= 1;
    for (int n = 0; n < 256; n++) wb(1, A_TX_CMD, 32'h0002_1008);
    rc(A_STATUS, 32'h0006_ff00);
    rc(A_TX_CMD, 32'h0002_0000);
    stall <= 0;
    while (sent < 255 && i++ < 1000) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(sent, 255);
    if (sent != 255) end_of_test();
  endtask : t_full
  task t_filt;
    for (int p = 0; p < 2; p++)
    begin
      wb(1, A_FCTL, p ? 32'h0111 : 32'h0121);
      wb(1, A_FTYPES, 2);
      wb(1, A_FID0, p ? 32'h8000_0007 : 0);
      for (int n = 5; n < 9; n++) evt(EVT_RX, n == 6 ? 2'h2 : 2'h1, n, n == 7, 0, 4'h1);
      for (int n = 0; n < 5; n++) wb(0, A_REC_POP, 0);
      rc(A_FCOUNT, p ? 1 : 2);
      rc(A_FID, p ? 7 : 8);
    end
  endtask : t_filt
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_types();
    t_reset();
    t_err();
    t_full();
    t_filt();
    end_of_test();
  end
endmodule : tb_can_event_fifo
